/* File: hdl/power_up_self_test_sequencer.v */
// power-up self-test sequencer: core check, functional checks, panel report
`timescale 1ns/1ps
`default_nettype none
`include "selftest_map.vh"
module power_up_self_test_sequencer
#(
  parameter integer BLINK_CYCLES = `ST_BLINK_CYCLES,
  parameter integer LAMP_WIDTH   = 8
)
(
  // clock and reset
  input  wire                  sys_clk,
  input  wire                  rst,
  // core processor check
  output reg                   coreStart,
  input  wire                  coreDone,
  input  wire                  corePass,
  input  wire [LAMP_WIDTH-1:0] coreFailPattern,
  // functional checks, one start per present check index 0-14
  output reg                   checkStart,
  output reg  [3:0]            checkIndex,
  input  wire                  checkDone,
  input  wire                  checkPass,
  input  wire [7:0]            checkFailCode,
  input  wire [15:0]           checkPresent,
  // front panel
  input  wire                  trigger_select_button,
  output reg                   trigger_lock_lamp,
  output reg  [LAMP_WIDTH-1:0] panelLamps,
  // readout message
  output reg                   readoutValid,
  output reg  [1:0]            readoutPrefix,
  output reg  [7:0]            readoutTestNum,
  output reg  [7:0]            readoutFailCode,
  // sequence status
  output reg                   normalOperation,
  output reg                   selfTestBusy
);
  localparam [2:0] S_CORE_START = 3'h0;
  localparam [2:0] S_CORE_WAIT  = 3'h1;
  localparam [2:0] S_CORE_FAIL  = 3'h2;
  localparam [2:0] S_CHK_START  = 3'h3;
  localparam [2:0] S_CHK_WAIT   = 3'h4;
  localparam [2:0] S_NEXT       = 3'h5;
  localparam [2:0] S_RUN        = 3'h6;

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [31:0] blinkCount_reg;
  wire       buttonRise;
  wire       coreFailEvent;
  wire       checkFailEvent;

  // terminal count of one blink half period
  localparam [31:0] BLINK_LAST = BLINK_CYCLES - 1;

  // check index to reported number: 0-5 base, 6 bus, 7 meter, 8-14 counter
  function [7:0] checkNumber;
    input [3:0] idx;
    begin
      if (idx < 4'h6)
        checkNumber = `ST_NUM_TIMING + {4'h0, idx};
      else if (idx == 4'h6)
        checkNumber = `ST_NUM_BUS;
      else if (idx == 4'h7)
        checkNumber = `ST_NUM_METER;
      else
        checkNumber = `ST_NUM_CTR_FIRST + {4'h0, idx - 4'h8};
    end
  endfunction

  function [1:0] checkPrefix;
    input [3:0] idx;
    begin
      if (idx < 4'h6)
        checkPrefix = `ST_PFX_NONE;
      else if (idx == 4'h6)
        checkPrefix = `ST_PFX_BUS;
      else if (idx == 4'h7)
        checkPrefix = `ST_PFX_METER;
      else
        checkPrefix = `ST_PFX_COUNTER;
    end
  endfunction

  button_sync u_button
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (trigger_select_button),
    .level   (),
    .rise    (buttonRise)
  );

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_CORE_START: state_next = S_CORE_WAIT;
      S_CORE_WAIT:
        if (coreDone)
          state_next = corePass ? S_CHK_START : S_CORE_FAIL;
      S_CORE_FAIL:
        if (buttonRise)
          state_next = S_RUN;
      S_CHK_START:
        if (!checkPresent[checkIndex])
          state_next = S_NEXT;
        else
          state_next = S_CHK_WAIT;
      S_CHK_WAIT:
        if (checkDone)
          state_next = S_NEXT;
      S_NEXT:
        if (checkIndex == `ST_LAST_CHECK)
          state_next = S_RUN;
        else
          state_next = S_CHK_START;
      S_RUN: state_next = S_RUN;
      default: state_next = S_CORE_START;
    endcase
  end

  // events that latch panel and readout state
  assign coreFailEvent  = (state_reg == S_CORE_WAIT) && coreDone && !corePass;
  assign checkFailEvent = (state_reg == S_CHK_WAIT) && checkDone && !checkPass;

  // sequencer state and start pulses
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg  <= S_CORE_START;
      coreStart  <= 1'b0;
      checkStart <= 1'b0;
      checkIndex <= 4'h0;
    end
    else
    begin
      state_reg  <= state_next;
      coreStart  <= (state_reg == S_CORE_START);
      checkStart <= (state_reg == S_CHK_START) && checkPresent[checkIndex];
      if (state_reg == S_NEXT)
        checkIndex <= checkIndex + 4'h1;
    end
  end

  // core failure display; blink runs until the operator steps in
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      blinkCount_reg    <= 32'h0;
      trigger_lock_lamp <= 1'b0;
      panelLamps        <= {LAMP_WIDTH{1'b0}};
    end
    else if (coreFailEvent)
    begin
      panelLamps        <= coreFailPattern;
      trigger_lock_lamp <= 1'b1;
      blinkCount_reg    <= 32'h0;
    end
    else if (state_reg == S_CORE_FAIL)
    begin
      if (buttonRise)
      begin
        // lamps released; outcome of running on a bad core is not guaranteed
        trigger_lock_lamp <= 1'b0;
        panelLamps        <= {LAMP_WIDTH{1'b0}};
      end
      else if (blinkCount_reg >= BLINK_LAST)
      begin
        blinkCount_reg    <= 32'h0;
        trigger_lock_lamp <= ~trigger_lock_lamp;
      end
      else
        blinkCount_reg <= blinkCount_reg + 32'h1;
    end
  end

  // first failure stays on the readout; later ones would hide it
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      readoutValid    <= 1'b0;
      readoutPrefix   <= `ST_PFX_NONE;
      readoutTestNum  <= 8'h00;
      readoutFailCode <= 8'h00;
    end
    else if (checkFailEvent && !readoutValid)
    begin
      readoutValid    <= 1'b1;
      readoutPrefix   <= checkPrefix(checkIndex);
      readoutTestNum  <= checkNumber(checkIndex);
      readoutFailCode <= checkFailCode;
    end
  end

  // status flags; they settle once the sequence hands over to normal running
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      normalOperation <= 1'b0;
      selfTestBusy    <= 1'b1;
    end
    else if (state_next == S_RUN)
    begin
      normalOperation <= 1'b1;
      selfTestBusy    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: inc/selftest_map.vh */
// constants for the power-up self-test sequencer
`ifndef SELFTEST_MAP_VH
`define SELFTEST_MAP_VH
`define ST_NUM_TIMING     8'h01
`define ST_NUM_SWITCH     8'h02
`define ST_NUM_READOUT    8'h03
`define ST_NUM_CALDATA    8'h04
`define ST_NUM_MAINBOARD  8'h05
`define ST_NUM_BATTERY    8'h06
`define ST_NUM_BUS        8'h11
`define ST_NUM_METER      8'h76
`define ST_NUM_CTR_FIRST  8'h81
`define ST_NUM_CTR_LAST   8'h87
`define ST_PFX_NONE       2'h0
`define ST_PFX_BUS        2'h1
`define ST_PFX_METER      2'h2
`define ST_PFX_COUNTER    2'h3
`define ST_BLINK_MS       250
`define ST_CLK_KHZ        40000
`define ST_BLINK_CYCLES   (`ST_BLINK_MS * `ST_CLK_KHZ)
`define ST_CHECK_COUNT    16
`define ST_LAST_CHECK     4'he
`endif

/* File: hdl/button_sync.v */
// three-stage synchroniser with agreement filter for a panel button
`timescale 1ns/1ps
`default_nettype none
module button_sync
(
  // clock and reset
  input  wire sys_clk,
  input  wire rst,
  // pin and result
  input  wire pinIn,
  output reg  level,
  output wire rise
);
  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;
  reg levelPrev_reg;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1_reg    <= 1'b0;
      stage2_reg    <= 1'b0;
      stage3_reg    <= 1'b0;
      level         <= 1'b0;
      levelPrev_reg <= 1'b0;
    end
    else
    begin
      stage1_reg    <= pinIn;
      stage2_reg    <= stage1_reg;
      stage3_reg    <= stage2_reg;
      // change counts only once stages two and three agree
      if (stage2_reg == stage3_reg)
        level <= stage3_reg;
      levelPrev_reg <= level;
    end
  end

  assign rise = level & ~levelPrev_reg;
endmodule
`default_nettype wire

/* File: verification/st_monitor.sv */
// checker for the self-test sequencer ports
`timescale 1ns/1ps
`default_nettype none
module st_monitor
#(
  parameter integer BLINK_CYCLES = 4,
  parameter integer LAMP_WIDTH   = 8
)
(
  // clock and reset
  input wire                  sys_clk,
  input wire                  rst,
  // core check
  input wire                  coreStart,
  input wire                  coreDone,
  input wire                  corePass,
  input wire [LAMP_WIDTH-1:0] coreFailPattern,
  // functional checks
  input wire                  checkStart,
  input wire                  checkDone,
  input wire                  checkPass,
  // panel and readout
  input wire                  trigger_select_button,
  input wire                  trigger_lock_lamp,
  input wire [LAMP_WIDTH-1:0] panelLamps,
  input wire                  readoutValid,
  input wire [7:0]            readoutTestNum,
  input wire                  normalOperation
);
  reg        coreBad_reg;
  reg [31:0] holdCnt_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // counter instead of repetition: blink length is a parameter
  always @(posedge sys_clk)
  begin
    coreBad_reg <= !rst && (coreBad_reg || (coreDone && !corePass));
    holdCnt_reg <= (rst || !trigger_lock_lamp) ? 32'h0 : holdCnt_reg + 32'h1;
  end
  sequence s_press;
    $rose(trigger_select_button) && coreBad_reg;
  endsequence
  property p_start; $fell(rst) |-> ##[1:3] coreStart; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_lamp; coreDone && !corePass |=> trigger_lock_lamp; endproperty
  a_lamp: assert property (p_lamp) else $error("no lamp");
  property p_blink; trigger_lock_lamp |-> holdCnt_reg < BLINK_CYCLES; endproperty
  a_blink: assert property (p_blink) else $error("no blink");
  property p_pat; $rose(trigger_lock_lamp) |-> panelLamps == coreFailPattern; endproperty
  a_pat: assert property (p_pat) else $error("bad pattern");
  property p_go; s_press |-> ##[2:8] normalOperation && !trigger_lock_lamp; endproperty
  a_go: assert property (p_go) else $error("no resume");
  property p_order; checkStart |-> !coreBad_reg; endproperty
  a_order: assert property (p_order) else $error("check after fail");
  property p_rep; $rose(readoutValid) |-> $past(checkDone) && !$past(checkPass); endproperty
  a_rep: assert property (p_rep) else $error("bad report");
  property p_hold; readoutValid |=> readoutValid && $stable(readoutTestNum); endproperty
  a_hold: assert property (p_hold) else $error("report lost");
endmodule
bind power_up_self_test_sequencer st_monitor #(.BLINK_CYCLES(BLINK_CYCLES),
  .LAMP_WIDTH(LAMP_WIDTH)) mon (.sys_clk, .rst, .coreStart, .coreDone, .corePass,
  .checkStart, .checkDone, .checkPass, .readoutValid, .trigger_select_button,
  .trigger_lock_lamp, .normalOperation, .coreFailPattern, .panelLamps, .readoutTestNum);
`default_nettype wire

/* File: verification/check_model.sv */
// partner model: core and functional check engines
`timescale 1ns/1ps
`default_nettype none
module check_model
(
  // requests
  input  wire       sys_clk,
  input  wire       coreStart,
  input  wire       checkStart,
  input  wire [3:0] checkIndex,
  // scenario controls
  input  wire       corePassCfg,
  input  wire [3:0] failIdx,
  // answers
  output reg        coreDone,
  output reg        corePass,
  output reg        checkDone,
  output reg        checkPass,
  output reg  [7:0] checkFailCode
);
  always @(posedge sys_clk)
  begin
    coreDone <= coreStart;
    corePass <= corePassCfg;
    checkDone <= checkStart;
    checkPass <= checkIndex != failIdx;
    checkFailCode <= {4'h0, checkIndex};
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the self-test sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  reg sys_clk = 0, rst = 1, trigger_select_button = 0, corePassCfg = 0;
  reg [3:0] failIdx = 0;
  reg [15:0] present = 16'hffff;
  wire coreStart, coreDone, corePass, checkStart, checkDone, checkPass, trigger_lock_lamp;
  wire readoutValid, normalOperation, selfTestBusy;
  wire [3:0] checkIndex;
  wire [1:0] readoutPrefix;
  wire [7:0] checkFailCode, panelLamps, readoutTestNum, readoutFailCode;
  integer miscompares = 0, checks = 0, starts = 0, k, i;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) starts <= rst ? 0 : starts + checkStart;
  power_up_self_test_sequencer #(.BLINK_CYCLES(4)) uut (.sys_clk, .rst, .coreStart,
    .coreDone, .corePass, .coreFailPattern(8'ha5), .checkStart, .checkIndex, .checkDone,
    .checkPass, .checkFailCode, .checkPresent(present), .trigger_select_button,
    .trigger_lock_lamp, .panelLamps, .readoutValid, .readoutPrefix, .readoutTestNum,
    .readoutFailCode, .normalOperation, .selfTestBusy);
  check_model partner (.sys_clk, .coreStart, .checkStart, .checkIndex, .corePassCfg,
    .failIdx, .coreDone, .corePass, .checkDone, .checkPass, .checkFailCode);
  task check(input [63:0] seen, input [63:0] exp, input [63:0] what);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // drives on rising edges only; rst is already high at time 0
  task restart(input pass, input [3:0] f);
  begin
    @(posedge sys_clk);
    rst <= 1;
    corePassCfg <= pass;
    failIdx <= f;
    repeat (2) @(posedge sys_clk);
    rst <= 0;
  end
  endtask
  // bounded wait for the end of the sequence
  task settle;
  begin
    k = 0;
    while (normalOperation !== 1 && k < 400)
    begin
      @(negedge sys_clk);
      k = k + 1;
    end
  end
  endtask
  task core_fail;
  begin
    restart(0, 0);
    repeat (8) @(negedge sys_clk);
    check(panelLamps, 8'ha5, "pattern");
    k = 0;
    repeat (16)
    begin
      @(negedge sys_clk);
      k = k + trigger_lock_lamp;
    end
    check(k, 8, "blink");
    check(starts, 0, "starts");
    @(posedge sys_clk);
    trigger_select_button <= 1;
    settle;
    check({trigger_lock_lamp, panelLamps, selfTestBusy}, 0, "lamps");
    check(normalOperation, 1, "resume");
    @(posedge sys_clk);
    trigger_select_button <= 0;
  end
  endtask
  task check_run(input [3:0] f, input [7:0] num, input [1:0] pfx);
  begin
    restart(1, f);
    settle;
    check({normalOperation, selfTestBusy}, 2'b10, "run");
    check(checkIndex, 4'hf, "index");
    check(starts, 15, "starts");
    check(readoutValid, f != 15, "valid");
    if (f != 15)
    begin
      check(readoutTestNum, num, "number");
      check(readoutPrefix, pfx, "prefix");
      check(readoutFailCode, f, "code");
    end
  end
  endtask
  // absent checks are skipped; a failure on one of them is never reported
  task skip_run;
  begin
    @(posedge sys_clk);
    present <= 16'h3f3f;
    restart(1, 7);
    settle;
    check({normalOperation, selfTestBusy}, 2'b10, "run");
    check(starts, 12, "skips");
    check(readoutValid, 0, "valid");
  end
  endtask
  task finish_test;
  begin
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  initial
  begin
    core_fail;
    for (i = 0; i < 16; i = i + 1)
      check_run(i, i < 6 ? i + 1 : i == 6 ? 8'h11 : i == 7 ? 8'h76 : 8'h79 + i,
        i < 6 ? 0 : i < 8 ? i - 5 : 3);
    skip_run;
    finish_test;
  end
  initial
  begin
    #300000;
    miscompares = miscompares + 1;
    finish_test;
  end
endmodule
`default_nettype wire
